// File: logic/ect_pkg.sv
// ect_pkg: shared constants and types of the dual 8-bit compare timer.
// assumes a 32-bit classic wishbone slave, word-aligned registers.
package ect_pkg;

  // bus geometry
  localparam int ECT_ADR_W = 18;
  localparam int ECT_IDX_W = 16;
  localparam int ECT_NUM_TMR = 2;
  localparam int ECT_CNT_W = 8;
  localparam int ECT_CFG_W = 6;

  // register indices; byte address is four times the index
  localparam logic [ECT_NUM_TMR-1:0][ECT_IDX_W-1:0] ECT_IDX_CNT = {16'hFF1F, 16'hFF16};
  localparam logic [ECT_NUM_TMR-1:0][ECT_IDX_W-1:0] ECT_IDX_CMP = {16'hFF41, 16'hFF17};
  localparam logic [ECT_NUM_TMR-1:0][ECT_IDX_W-1:0] ECT_IDX_CTRL = {16'hFF81, 16'hFF80};
  localparam logic [ECT_IDX_W-1:0] ECT_IDX_STAT = 16'hFF82;
  localparam logic [ECT_IDX_W-1:0] ECT_IDX_MASK = 16'hFF83;

  // reset values
  localparam logic [ECT_CNT_W-1:0] ECT_CNT_RST = 8'h00;
  localparam logic [ECT_CNT_W-1:0] ECT_CMP_RST = 8'h00;
  localparam logic [ECT_CFG_W-1:0] ECT_CFG_RST = 6'h00;
  localparam logic [ECT_NUM_TMR-1:0] ECT_IRQ_RST = 2'h0;

  // prescaler: log2 of the divide ratio for each count clock select code
  localparam int ECT_PRE_W = 12;
  localparam logic [7:0][3:0] ECT_DIV_LOG2 = {4'h3, 4'h9, 4'h7, 4'hC, 4'h6, 4'h4, 4'h2, 4'h0};

  // mode control bit: zero selects clear and start on match
  typedef enum logic {ECT_MODE_CLEAR_START, ECT_MODE_PWM} ect_mode_t;

  // control register layout, bit 5 down to bit 0
  typedef struct packed {
    logic level;
    logic [2:0] clkSel;
    ect_mode_t mode;
    logic enable;
  } ect_cfg_t;

endpackage

// File: logic/ect_prescaler.sv
// ect_prescaler: free-running divider making count clock strobes.
// assumes one peripheral clock; strobes are one cycle wide.
`timescale 1ns/100ps
module ect_prescaler import ect_pkg::*; #(
  parameter int PRE_W = ECT_PRE_W
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // one strobe per select code
  output logic [7:0] tick
);

  logic [PRE_W-1:0] preCount;
  logic [PRE_W-1:0] next_pre;
  logic [7:0] next_tick;

  if (PRE_W < ECT_PRE_W) begin : g_bad_width
    $error("ect_prescaler: PRE_W too small for the largest divide ratio");
  end

  // low bits that must all be one for a strobe of the given ratio
  function automatic logic [PRE_W-1:0] lowMask(input logic [3:0] log2);
    lowMask = PRE_W'((1 << log2) - 1);
  endfunction

  // strobes are taken from the next count so they line up with it
  always_comb begin
    next_pre = PRE_W'(preCount + 1'b1);
    for (int k = 0; k < 8; k++) begin
      next_tick[k] = &(next_pre | ~lowMask(ECT_DIV_LOG2[k]));
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      preCount <= '0;
      tick <= 8'h00;
    end else begin
      preCount <= next_pre;
      tick <= next_tick;
    end
  end

endmodule

// File: logic/ect_timer.sv
// ect_timer: one up-counter with compare, clear-and-start and pwm modes.
// assumes tick is a one-cycle strobe from the shared prescaler.
`timescale 1ns/100ps
module ect_timer import ect_pkg::*; #(
  parameter int WIDTH = ECT_CNT_W
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // configuration from software
  input wire ect_cfg_t cfg,
  input wire logic tick,
  input wire logic [WIDTH-1:0] compare,
  // state and events
  output logic [WIDTH-1:0] count,
  output logic matchIrq,
  output logic outPin
);

  logic active;
  logic next_active;
  logic next_pin;
  logic next_match;
  logic [WIDTH-1:0] next_count;
  logic equal;

  if (WIDTH < 1 || WIDTH > 16) begin : g_bad_width
    $error("ect_timer: WIDTH must be 1 to 16");
  end

  assign equal = (count == compare);

  // counter, match and output level; a disable wins over a pending tick
  always_comb begin
    next_count = count;
    next_active = active;
    next_match = 1'b0;
    if (!cfg.enable) begin
      next_count = '0;
      next_active = 1'b0;
    end else if (tick) begin
      if (cfg.mode == ECT_MODE_PWM) begin
        next_count = WIDTH'(count + 1'b1);
        if (count == '1) begin
          next_active = 1'b1;
        end
        if (equal) begin
          next_active = 1'b0;
        end
      end else if (equal) begin
        next_count = '0;
        next_match = 1'b1;
        next_active = ~active;
      end else begin
        next_count = WIDTH'(count + 1'b1);
      end
    end
    next_pin = cfg.level ? next_active : ~next_active;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      count <= '0;
      active <= 1'b0;
      matchIrq <= 1'b0;
      outPin <= 1'b0;
    end else begin
      count <= next_count;
      active <= next_active;
      matchIrq <= next_match;
      outPin <= next_pin;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_run_tick;
    cfg.enable && tick;
  endsequence

  sequence s_pwm_wrap;
    s_run_tick ##0 cfg.mode == ECT_MODE_PWM && count == '1 && !equal;
  endsequence

  a_count_step: assert property (s_run_tick ##0 (cfg.mode == ECT_MODE_PWM || !equal)
      |=> count == WIDTH'($past(count) + 1'b1))
    else $error("count did not step by one on a tick");
  a_count_hold: assert property (cfg.enable && !tick |=> $stable(count))
    else $error("count moved without a tick");
  a_disable_clear: assert property (!cfg.enable |=> count == '0 && !matchIrq)
    else $error("disabled timer did not clear");
  a_match_clear: assert property (s_run_tick ##0 cfg.mode == ECT_MODE_CLEAR_START && equal
      |=> count == '0 && matchIrq ##1 !matchIrq || tick)
    else $error("match in clear-and-start mode misbehaved");
  a_pwm_no_irq: assert property (cfg.mode == ECT_MODE_PWM |=> !matchIrq)
    else $error("interrupt raised in pwm mode");
  a_pwm_inactive: assert property (s_run_tick ##0 cfg.mode == ECT_MODE_PWM && equal
      |=> outPin != $past(cfg.level))
    else $error("pwm output not inactive after match");
  a_pwm_wrap: assert property (s_pwm_wrap |=> count == '0 && outPin == $past(cfg.level))
    else $error("pwm output not active at wrap");

endmodule

// File: logic/ect_top.sv
// ect_top: two 8-bit compare timers behind a classic wishbone slave.
// assumes a 32-bit wishbone master on the same clock; registers in bits 7:0.
//
// The Wishbone slave port was left to the implementer.
`timescale 1ns/100ps
module ect_top import ect_pkg::*; (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ECT_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // timer pins and events
  output logic [ECT_NUM_TMR-1:0] timerOutPin,
  output logic [ECT_NUM_TMR-1:0] matchIrq,
  // interrupt
  output logic irq
);

  logic [ECT_IDX_W-1:0] reqIdx;
  logic busReq;
  logic busWrite;
  logic [31:0] rdData;
  logic [7:0] tickVec;
  logic [ECT_NUM_TMR-1:0] tmrTick;

  logic [ECT_CNT_W-1:0] count [ECT_NUM_TMR];
  logic [ECT_CNT_W-1:0] cmp [ECT_NUM_TMR];
  logic [ECT_CNT_W-1:0] next_cmp [ECT_NUM_TMR];
  ect_cfg_t cfg [ECT_NUM_TMR];
  ect_cfg_t next_cfg [ECT_NUM_TMR];
  logic [ECT_NUM_TMR-1:0] status;
  logic [ECT_NUM_TMR-1:0] next_status;
  logic [ECT_NUM_TMR-1:0] mask;
  logic [ECT_NUM_TMR-1:0] next_mask;
  logic next_irq;
  logic next_ack;
  logic [31:0] next_dat;

  // word index of the access; the two low address bits are ignored
  assign reqIdx = wb_adr_i[ECT_ADR_W-1:2];
  assign busReq = wb_cyc_i & wb_stb_i;
  // writes take effect on the edge where ack is seen, lane 0 only
  assign busWrite = busReq & wb_we_i & wb_ack_o & wb_sel_i[0];

  // address compare shared by the write and read paths
  function automatic logic isReg(input logic [ECT_IDX_W-1:0] idx,
                                 input logic [ECT_IDX_W-1:0] target);
    isReg = (idx == target);
  endfunction

  // shared divider; each timer picks its own strobe
  ect_prescaler #(
    .PRE_W(ECT_PRE_W)
  ) u_prescaler (
    .clock(clock),
    .rst_n(rst_n),
    .tick(tickVec)
  );

  for (genvar i = 0; i < ECT_NUM_TMR; i++) begin : g_tmr
    assign tmrTick[i] = tickVec[cfg[i].clkSel];

    ect_timer #(
      .WIDTH(ECT_CNT_W)
    ) u_timer (
      .clock(clock),
      .rst_n(rst_n),
      .cfg(cfg[i]),
      .tick(tmrTick[i]),
      .compare(cmp[i]),
      .count(count[i]),
      .matchIrq(matchIrq[i]),
      .outPin(timerOutPin[i])
    );
  end

  // register writes; counter indices have no write path at all
  always_comb begin
    next_cmp = cmp;
    next_cfg = cfg;
    next_mask = mask;
    next_status = status | matchIrq; // a new event outranks a clear
    if (busWrite) begin
      for (int i = 0; i < ECT_NUM_TMR; i++) begin
        if (isReg(reqIdx, ECT_IDX_CMP[i])) begin
          next_cmp[i] = wb_dat_i[ECT_CNT_W-1:0];
        end
        if (isReg(reqIdx, ECT_IDX_CTRL[i])) begin
          next_cfg[i] = ect_cfg_t'(wb_dat_i[ECT_CFG_W-1:0]);
        end
      end
      if (isReg(reqIdx, ECT_IDX_STAT)) begin
        next_status = (status & ~wb_dat_i[ECT_NUM_TMR-1:0]) | matchIrq;
      end
      if (isReg(reqIdx, ECT_IDX_MASK)) begin
        next_mask = wb_dat_i[ECT_NUM_TMR-1:0];
      end
    end
    next_irq = |(next_status & next_mask);
  end

  // control, compare and interrupt state
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      for (int i = 0; i < ECT_NUM_TMR; i++) begin
        cmp[i] <= ECT_CMP_RST;
        cfg[i] <= ect_cfg_t'(ECT_CFG_RST);
      end
      status <= ECT_IRQ_RST;
      mask <= ECT_IRQ_RST;
      irq <= 1'b0;
    end else begin
      cmp <= next_cmp;
      cfg <= next_cfg;
      status <= next_status;
      mask <= next_mask;
      irq <= next_irq;
    end
  end

  // read mux; unmapped indices read as zero
  always_comb begin
    rdData = 32'h0000_0000;
    for (int i = 0; i < ECT_NUM_TMR; i++) begin
      if (isReg(reqIdx, ECT_IDX_CNT[i])) begin
        rdData[ECT_CNT_W-1:0] = count[i];
      end
      if (isReg(reqIdx, ECT_IDX_CMP[i])) begin
        rdData[ECT_CNT_W-1:0] = cmp[i];
      end
      if (isReg(reqIdx, ECT_IDX_CTRL[i])) begin
        rdData[ECT_CFG_W-1:0] = cfg[i];
      end
    end
    if (isReg(reqIdx, ECT_IDX_STAT)) begin
      rdData[ECT_NUM_TMR-1:0] = status;
    end
    if (isReg(reqIdx, ECT_IDX_MASK)) begin
      rdData[ECT_NUM_TMR-1:0] = mask;
    end
  end

  // one wait state: ack in the cycle after the request is seen, then drop
  always_comb begin
    next_ack = busReq & ~wb_ack_o;
    next_dat = wb_dat_o;
    if (next_ack) begin
      next_dat = rdData; // captured one edge before the master takes it
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_cmp0_write;
    busWrite && isReg(reqIdx, ECT_IDX_CMP[0]);
  endsequence

  a_reset_values: assert property ($rose(rst_n) |-> cmp[0] == ECT_CMP_RST
      && cmp[1] == ECT_CMP_RST && count[0] == ECT_CNT_RST && count[1] == ECT_CNT_RST)
    else $error("counter or compare not zero after reset");
  a_cmp_write: assert property (s_cmp0_write |=> cmp[0] == $past(wb_dat_i[7:0]))
    else $error("compare write not stored");
  a_irq_raise: assert property (matchIrq[0] && mask[0] && !busWrite |=> irq && status[0])
    else $error("unmasked match did not raise interrupt");
  a_ack_once: assert property (busReq && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("wishbone ack not a single cycle");

  // writes to the second compare and to both control words
  sequence s_cmp1_write;
    busWrite && isReg(reqIdx, ECT_IDX_CMP[1]);
  endsequence

  sequence s_ctrl0_write;
    busWrite && isReg(reqIdx, ECT_IDX_CTRL[0]);
  endsequence

  sequence s_ctrl1_write;
    busWrite && isReg(reqIdx, ECT_IDX_CTRL[1]);
  endsequence

  a_cmp1_store: assert property (s_cmp1_write |=> cmp[1] == $past(wb_dat_i[7:0]))
    else $error("second compare write not stored");
  a_ctrl0_store: assert property (s_ctrl0_write
      |=> cfg[0] == ect_cfg_t'($past(wb_dat_i[ECT_CFG_W-1:0])))
    else $error("first control write not stored");
  a_ctrl1_store: assert property (s_ctrl1_write
      |=> cfg[1] == ect_cfg_t'($past(wb_dat_i[ECT_CFG_W-1:0])))
    else $error("second control write not stored");

  // compare only moves on a taken write; a refused write leaves it alone
  a_cmp_steady: assert property (!busWrite |=> $stable(cmp[0]) && $stable(cmp[1]))
    else $error("compare changed without a write");

  // status is sticky and a new match outranks a clear in the same cycle
  a_status_set0: assert property (matchIrq[0] |=> status[0])
    else $error("match on timer 0 not recorded");
  a_status_set1: assert property (matchIrq[1] |=> status[1])
    else $error("match on timer 1 not recorded");
  a_status_clear: assert property (busWrite && isReg(reqIdx, ECT_IDX_STAT) && wb_dat_i[0]
      && !matchIrq[0] |=> !status[0])
    else $error("status bit not cleared by a one");

  // mask register and the level interrupt that follows it
  a_mask_store: assert property (busWrite && isReg(reqIdx, ECT_IDX_MASK)
      |=> mask == $past(wb_dat_i[ECT_NUM_TMR-1:0]))
    else $error("mask write not stored");
  a_irq_level: assert property (irq == |(status & mask))
    else $error("interrupt does not follow status and mask");

  // bus side: no ack without a request, read data taken from the register
  a_ack_idle: assert property (!busReq |=> !wb_ack_o)
    else $error("ack without a request");
  a_read_cmp: assert property (busReq && !wb_ack_o && !wb_we_i
      && isReg(reqIdx, ECT_IDX_CMP[0]) |=> wb_dat_o[7:0] == $past(cmp[0]))
    else $error("compare read returned wrong data");
  a_read_cnt: assert property (busReq && !wb_ack_o && !wb_we_i
      && isReg(reqIdx, ECT_IDX_CNT[1]) |=> wb_dat_o[7:0] == $past(count[1]))
    else $error("counter read returned wrong data");

  // outputs quiet right after reset is released
  a_reset_outputs: assert property ($rose(rst_n)
      |-> !irq && !wb_ack_o && matchIrq == '0 && status == '0)
    else $error("outputs not quiet after reset");

endmodule

// File: tb/ect_top_tb.sv
// ect_top_tb: self-checking bench for the dual 8-bit compare timer.
// assumes ect_pkg and ect_top are compiled first; the bench drives the wishbone side itself.
`timescale 1ns/100ps
module ect_top_tb import ect_pkg::*;;
  // clock, reset and bus signals
  logic clock;
  logic rst_n;
  logic wbCyc;
  logic wbStb;
  logic wbWe;
  logic [ECT_ADR_W-1:0] wbAdr;
  logic [3:0] wbSel;
  logic [31:0] wbDatI;
  logic [31:0] wbDatO;
  logic wbAck;
  logic [ECT_NUM_TMR-1:0] outPin;
  logic [ECT_NUM_TMR-1:0] matchIrq;
  logic irq;
  // bookkeeping
  int num_errors;
  int n_compared;
  int cycles;
  int n;
  int hi;
  int lo;
  logic [31:0] rd;
  logic [31:0] c1;
  logic [7:0] pat [3] = '{8'hFF, 8'h00, 8'h5A};

  ect_top dut_u (
    .clock(clock),
    .rst_n(rst_n),
    .wb_cyc_i(wbCyc),
    .wb_stb_i(wbStb),
    .wb_we_i(wbWe),
    .wb_adr_i(wbAdr),
    .wb_sel_i(wbSel),
    .wb_dat_i(wbDatI),
    .wb_dat_o(wbDatO),
    .wb_ack_o(wbAck),
    .timerOutPin(outPin),
    .matchIrq(matchIrq),
    .irq(irq)
  );

  // 20 MHz clock
  always #25 clock = ~clock;

  // hang guard; the whole run needs well under 6000 cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // range compare; an unknown value never lands inside the range
  task automatic chkr(input string what, input int lo, input int hi, input logic [31:0] got);
    n_compared++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      num_errors++;
      $display("ERROR %s expected %0d..%0d seen %h", what, lo, hi, got);
    end
  endtask

  // one classic cycle; request held until ack is sampled high
  task automatic bus(input logic we, input logic [ECT_IDX_W-1:0] idx, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clock);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= {idx, 2'b00};
    wbSel <= 4'hF;
    wbDatI <= d;
    do @(posedge clock); while (wbAck !== 1'b1);
    q = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
  endtask

  task automatic wr(input logic [ECT_IDX_W-1:0] idx, input logic [31:0] d);
    bus(1'b1, idx, d, rd);
  endtask

  task automatic rdc(input string what, input logic [ECT_IDX_W-1:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0, rd);
    chk(what, exp, rd);
  endtask

  // main sequence
  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    wbCyc = 1'b0;
    wbStb = 1'b0;
    wbWe = 1'b0;
    wbAdr = '0;
    wbSel = 4'h0;
    wbDatI = 32'h0;
    num_errors = 0;
    n_compared = 0;
    cycles = 0;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      rdc("count reset", ECT_IDX_CNT[k], 32'h0);
      rdc("compare reset", ECT_IDX_CMP[k], 32'h0);
    end
    rdc("unmapped", 16'h0000, 32'h0);
    // both ends of the compare range and a mixed pattern
    for (int j = 0; j < 3; j++) begin
      for (int k = 0; k < 2; k++) begin
        wr(ECT_IDX_CMP[k], {24'h0, pat[j]});
        rdc("compare rw", ECT_IDX_CMP[k], {24'h0, pat[j]});
      end
    end
    // every count clock select; reads are 203 cycles apart, prescaler phase unknown
    for (int k = 0; k < 8; k++) begin
      wr(ECT_IDX_CTRL[0], 32'h0);
      wr(ECT_IDX_CMP[0], 32'hFF); // compare changed only while stopped
      wr(ECT_IDX_CTRL[0], 32'(k * 4 + 1));
      bus(1'b0, ECT_IDX_CNT[0], 32'h0, c1);
      wr(ECT_IDX_CNT[0], 32'hFF); // a taken write would spoil the delta
      repeat (197) @(posedge clock);
      bus(1'b0, ECT_IDX_CNT[0], 32'h0, rd);
      lo = 203 >> ECT_DIV_LOG2[k];
      chkr("count delta", lo, lo + 1, {24'h0, rd[7:0] - c1[7:0]});
    end
    // clear-and-start, compare 5, divide 1: period of six cycles
    wr(ECT_IDX_CTRL[0], 32'h0);
    wr(ECT_IDX_CMP[0], 32'h05);
    wr(ECT_IDX_STAT, 32'h3);
    wr(ECT_IDX_CTRL[0], 32'h01); // mode bit zero
    n = 0;
    repeat (60) begin
      @(posedge clock);
      if (matchIrq[0] === 1'b1) n++;
    end
    chk("match pulses", 32'd9, n);
    bus(1'b0, ECT_IDX_CNT[0], 32'h0, rd);
    chkr("count bound", 0, 5, rd);
    rdc("status", ECT_IDX_STAT, 32'h1);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(ECT_IDX_MASK, 32'h1);
    repeat (2) @(posedge clock);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    // stopping clears the count; then the sticky bit is cleared
    wr(ECT_IDX_CTRL[0], 32'h0);
    repeat (10) @(posedge clock);
    rdc("count stopped", ECT_IDX_CNT[0], 32'h0);
    chk("pin stopped", 32'h1, {31'h0, outPin[0]}); // inactive with level low
    wr(ECT_IDX_STAT, 32'h1);
    repeat (2) @(posedge clock);
    chk("irq cleared", 32'h0, {31'h0, irq});
    rdc("status cleared", ECT_IDX_STAT, 32'h0);
    // pwm on timer 1, active high, compare 0x40: starts inactive, active 65 after wrap
    wr(ECT_IDX_CMP[1], 32'h40); // single rewrite
    wr(ECT_IDX_CTRL[1], 32'h23);
    n = 0;
    hi = 0;
    repeat (512) begin
      @(posedge clock);
      if (matchIrq[1] === 1'b1) n++;
      if (outPin[1] === 1'b1) hi++;
    end
    chk("pwm requests", 32'h0, n);
    chkr("pwm active", 63, 67, hi);
    rdc("pwm status", ECT_IDX_STAT, 32'h0);
    stop_test();
  end
endmodule
